//--- pin_function_mux.sv
// general-pin function selection and target address unlock key
// What this block does
// [R1] first pin selector is five bits, register bits 4:0, reset zero
// [R2] first pin selector zero gives the legacy interrupt pin behaviour
// [R3] code one drives interrupt using polarity, drive style and enable configuration
// [R4] code two asserts pin from first slot start to last slot end
// [R5] codes five, six, seven output slot A, slot B, both pulse trains
// [R6] codes 0xC, 0xD, 0xE show data cycle for A, B, either
// [R7] code 0xF toggles pin every sample, half sampling rate square wave
// [R8] 0x10 low, 0x11 high, 0x13 forwards the 32 kHz oscillator
// [R9] software must program only listed function codes
// [R10] second pin selector supports codes 0x01 to 0x13 identically
// [R11] sixteen bit read/write unlock key, reset zero, gates address changes
// [R12] key 0x04AD permits address change always
// [R13] key 0x44AD permits change only while first pin is high
// [R14] key 0x84AD needs second pin high; 0xC4AD needs both high
// [R15] software writes 0xAD in upper byte of address write
// [R16] target address in bits 7:1, reset 0x64
// [R17] address writes ignored unless key and pin condition permit
`timescale 1ns/1ns
`default_nettype none
module pin_function_mux (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial host port register access
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // interrupt pin configuration from its register
  input wire logic int_pol,
  input wire logic int_drv,
  input wire logic int_ena,
  // internal sources
  input wire logic irq,
  input wire logic slot_window,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic data_cycle_a,
  input wire logic data_cycle_b,
  input wire logic sample_strobe,
  input wire logic osc32k,
  // general pins
  input wire logic pin0_in,
  output logic pin0_out,
  output logic pin0_oe,
  input wire logic pin1_in,
  output logic pin1_out,
  output logic pin1_oe,
  // current target address
  output logic [6:0] target_addr
);

  logic [4:0] sel0_reg, sel0_next, sel1_reg, sel1_next;
  logic [15:0] key_reg, key_next;
  logic [6:0] addr_reg, addr_next;
  logic [15:0] rdata_reg, rdata_next;
  logic toggle_reg, toggle_next;
  logic [2:0] p0_sync_reg, p1_sync_reg, osc_sync_reg;
  logic [2:0] p0_sync_next, p1_sync_next, osc_sync_next;
  logic p0_lvl_reg, p1_lvl_reg, osc_lvl_reg;
  logic p0_lvl_next, p1_lvl_next, osc_lvl_next;
  logic [1:0] drv0_reg, drv1_reg, drv0_next, drv1_next;
  logic addr_wr, addr_ok;

  localparam logic [4:0] SEL_LEGACY_C = pin_mux_pkg::SEL_LEGACY;
  localparam logic [4:0] SEL_INT_C = pin_mux_pkg::SEL_INT;
  localparam logic [4:0] SEL_SLOT_WIN_C = pin_mux_pkg::SEL_SLOT_WIN;
  localparam logic [4:0] SEL_PULSE_A_C = pin_mux_pkg::SEL_PULSE_A;
  localparam logic [4:0] SEL_PULSE_B_C = pin_mux_pkg::SEL_PULSE_B;
  localparam logic [4:0] SEL_PULSE_AB_C = pin_mux_pkg::SEL_PULSE_AB;
  localparam logic [4:0] SEL_DATA_A_C = pin_mux_pkg::SEL_DATA_A;
  localparam logic [4:0] SEL_DATA_B_C = pin_mux_pkg::SEL_DATA_B;
  localparam logic [4:0] SEL_DATA_AB_C = pin_mux_pkg::SEL_DATA_AB;
  localparam logic [4:0] SEL_TOGGLE_C = pin_mux_pkg::SEL_TOGGLE;
  localparam logic [4:0] SEL_LOW_C = pin_mux_pkg::SEL_LOW;
  localparam logic [4:0] SEL_HIGH_C = pin_mux_pkg::SEL_HIGH;
  localparam logic [4:0] SEL_OSC_C = pin_mux_pkg::SEL_OSC;

  // picks {oe, level} for one pin; pin 1 legacy leaves the pin released
  function automatic logic [1:0] pin_drive(input logic [4:0] sel, input logic is_pin0,
                                           input logic tog, input logic osc);
    logic act;
    act = irq ^ int_pol;
    case (sel)
      SEL_LEGACY_C: pin_drive = is_pin0 ? {int_ena & (~int_drv | irq), act} : 2'h0; // R2
      SEL_INT_C: pin_drive = {int_ena & (~int_drv | irq), act}; // R3
      SEL_SLOT_WIN_C: pin_drive = {1'b1, slot_window}; // R4
      SEL_PULSE_A_C: pin_drive = {1'b1, pulse_a}; // R5
      SEL_PULSE_B_C: pin_drive = {1'b1, pulse_b}; // R5
      SEL_PULSE_AB_C: pin_drive = {1'b1, pulse_a | pulse_b}; // R5
      SEL_DATA_A_C: pin_drive = {1'b1, data_cycle_a}; // R6
      SEL_DATA_B_C: pin_drive = {1'b1, data_cycle_b}; // R6
      SEL_DATA_AB_C: pin_drive = {1'b1, data_cycle_a | data_cycle_b}; // R6
      SEL_TOGGLE_C: pin_drive = {1'b1, tog}; // R7
      SEL_LOW_C: pin_drive = 2'h2; // R8
      SEL_HIGH_C: pin_drive = 2'h3; // R8
      SEL_OSC_C: pin_drive = {1'b1, osc}; // R8
      // unsupported codes simply release the pin
      default: pin_drive = 2'h0;
    endcase
  endfunction

  // pin levels and the oscillator arrive from outside: three stages, agree on last two
  always_comb begin
    p0_sync_next = {p0_sync_reg[1:0], pin0_in};
    p1_sync_next = {p1_sync_reg[1:0], pin1_in};
    osc_sync_next = {osc_sync_reg[1:0], osc32k};
    p0_lvl_next = (p0_sync_reg[2] == p0_sync_reg[1]) ? p0_sync_reg[2] : p0_lvl_reg;
    p1_lvl_next = (p1_sync_reg[2] == p1_sync_reg[1]) ? p1_sync_reg[2] : p1_lvl_reg;
    osc_lvl_next = (osc_sync_reg[2] == osc_sync_reg[1]) ? osc_sync_reg[2] : osc_lvl_reg;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      p0_sync_reg <= 3'h0;
      p1_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
      p0_lvl_reg <= 1'b0;
      p1_lvl_reg <= 1'b0;
      osc_lvl_reg <= 1'b0;
    end else begin
      p0_sync_reg <= p0_sync_next;
      p1_sync_reg <= p1_sync_next;
      osc_sync_reg <= osc_sync_next;
      p0_lvl_reg <= p0_lvl_next;
      p1_lvl_reg <= p1_lvl_next;
      osc_lvl_reg <= osc_lvl_next;
    end
  end

  // key decides whether a target address write lands
  always_comb begin
    addr_wr = reg_wr && (reg_addr == pin_mux_pkg::ADDR_REG_OFS) &&
              (reg_wdata[pin_mux_pkg::WKEY_LSB +: 8] == pin_mux_pkg::ADDR_WRITE_KEY); // R15
    if (key_reg == pin_mux_pkg::KEY_ALWAYS) begin
      addr_ok = 1'b1; // R12
    end else if (key_reg == pin_mux_pkg::KEY_PIN0) begin
      addr_ok = p0_lvl_reg; // R13
    end else if (key_reg == pin_mux_pkg::KEY_PIN1) begin
      addr_ok = p1_lvl_reg; // R14
    end else if (key_reg == pin_mux_pkg::KEY_BOTH) begin
      addr_ok = p0_lvl_reg & p1_lvl_reg; // R14
    end else begin
      addr_ok = 1'b0; // R17
    end
  end

  // register writes and reads
  always_comb begin
    sel0_next = sel0_reg;
    sel1_next = sel1_reg;
    key_next = key_reg;
    addr_next = addr_reg;
    rdata_next = rdata_reg;
    if (reg_wr && reg_addr == pin_mux_pkg::PIN_SEL_OFS) begin
      sel0_next = reg_wdata[pin_mux_pkg::SEL0_LSB +: pin_mux_pkg::SEL_W]; // R1
      sel1_next = reg_wdata[pin_mux_pkg::SEL1_LSB +: pin_mux_pkg::SEL_W]; // R10
    end
    if (reg_wr && reg_addr == pin_mux_pkg::KEY_OFS) begin
      key_next = reg_wdata; // R11
    end
    if (addr_wr && addr_ok) begin
      addr_next = reg_wdata[pin_mux_pkg::ADDR_LSB +: pin_mux_pkg::ADDR_W]; // R16
    end
    if (reg_rd) begin
      if (reg_addr == pin_mux_pkg::PIN_SEL_OFS) begin
        rdata_next = {3'h0, sel1_reg, 3'h0, sel0_reg};
      end else if (reg_addr == pin_mux_pkg::KEY_OFS) begin
        rdata_next = key_reg;
      end else if (reg_addr == pin_mux_pkg::ADDR_REG_OFS) begin
        rdata_next = {8'h00, addr_reg, 1'b0};
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  // toggle runs freely on each sample so both pins see the same phase
  always_comb begin
    toggle_next = sample_strobe ? ~toggle_reg : toggle_reg; // R7
    drv0_next = pin_drive(sel0_reg, 1'b1, toggle_reg, osc_lvl_reg);
    drv1_next = pin_drive(sel1_reg, 1'b0, toggle_reg, osc_lvl_reg);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel0_reg <= pin_mux_pkg::SEL_RESET; // R1
      sel1_reg <= pin_mux_pkg::SEL_RESET;
      key_reg <= pin_mux_pkg::KEY_RESET; // R11
      addr_reg <= pin_mux_pkg::ADDR_RESET; // R16
      rdata_reg <= 16'h0000;
      toggle_reg <= 1'b0;
      drv0_reg <= 2'h0;
      drv1_reg <= 2'h0;
    end else begin
      sel0_reg <= sel0_next;
      sel1_reg <= sel1_next;
      key_reg <= key_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      toggle_reg <= toggle_next;
      drv0_reg <= drv0_next;
      drv1_reg <= drv1_next;
    end
  end

  assign pin0_oe = drv0_reg[1];
  assign pin0_out = drv0_reg[0];
  assign pin1_oe = drv1_reg[1];
  assign pin1_out = drv1_reg[0];
  assign reg_rdata = rdata_reg;
  assign target_addr = addr_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_sel_reset: assert property ($fell(rst) |-> sel0_reg == 5'h00 && sel1_reg == 5'h00) // R1
    else $error("selector not zero after reset");
  chk_int_drive: assert property (sel0_reg == 5'h01 && int_ena && !int_drv
    |=> pin0_oe && pin0_out == ($past(irq) ^ $past(int_pol))) // R3
    else $error("interrupt function wrong on first pin");
  chk_slot_window: assert property (sel0_reg == 5'h02 |=> pin0_oe && pin0_out == $past(slot_window)) // R4
    else $error("slot window not on pin");
  chk_pulse_both: assert property (sel1_reg == 5'h07 |=> pin1_oe && pin1_out == ($past(pulse_a) | $past(pulse_b))) // R5
    else $error("combined pulse train wrong");
  chk_data_any: assert property (sel1_reg == 5'h0e |=> pin1_out == ($past(data_cycle_a) | $past(data_cycle_b))) // R6
    else $error("data cycle indication wrong");
  chk_toggle_rate: assert property (sel0_reg == 5'h0f && sample_strobe ##1 sel0_reg == 5'h0f
    |=> pin0_out != $past(pin0_out)) // R7
    else $error("pin did not toggle on sample");
  chk_const_level: assert property (sel0_reg == 5'h10 && sel1_reg == 5'h11
    |=> !pin0_out && pin0_oe && pin1_out && pin1_oe) // R8
    else $error("constant level wrong");
  chk_key_open: assert property (addr_wr && key_reg == 16'h04ad
    |=> {8'h00, addr_reg, 1'b0} == ($past(reg_wdata) & 16'h00fe)) // R12
    else $error("unlocked address write lost");
  chk_key_pin0: assert property (addr_wr && key_reg == 16'h44ad && !p0_lvl_reg |=> $stable(addr_reg)) // R13
    else $error("address changed with first pin low");
  chk_key_both: assert property (addr_wr && key_reg == 16'hc4ad && p0_lvl_reg && p1_lvl_reg
    |=> {8'h00, addr_reg, 1'b0} == ($past(reg_wdata) & 16'h00fe)) // R14
    else $error("address write refused with both pins high");
  chk_key_locked: assert property (key_reg != 16'h04ad && key_reg != 16'h44ad && key_reg != 16'h84ad
    && key_reg != 16'hc4ad |=> $stable(addr_reg)) // R17
    else $error("address changed while locked");

endmodule // pin_function_mux
`default_nettype wire

//--- pin_mux_pkg.sv
// constants for the general-pin function selectors and the address unlock key
package pin_mux_pkg;
  // register offsets on the serial host port
  localparam logic [7:0] ADDR_REG_OFS = 8'h09;
  localparam logic [7:0] PIN_SEL_OFS = 8'h0b;
  localparam logic [7:0] KEY_OFS = 8'h0d;
  // field positions
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 8;
  localparam int SEL_W = 5;
  localparam int ADDR_LSB = 1;
  localparam int ADDR_W = 7;
  localparam int WKEY_LSB = 8;
  // reset values
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [15:0] KEY_RESET = 16'h0000;
  localparam logic [6:0] ADDR_RESET = 7'h32;
  // byte that must accompany a target address write
  localparam logic [7:0] ADDR_WRITE_KEY = 8'had;
  // unlock key codes
  localparam logic [15:0] KEY_ALWAYS = 16'h04ad;
  localparam logic [15:0] KEY_PIN0 = 16'h44ad;
  localparam logic [15:0] KEY_PIN1 = 16'h84ad;
  localparam logic [15:0] KEY_BOTH = 16'hc4ad;
  // function codes
  localparam logic [4:0] SEL_LEGACY = 5'h00;
  localparam logic [4:0] SEL_INT = 5'h01;
  localparam logic [4:0] SEL_SLOT_WIN = 5'h02;
  localparam logic [4:0] SEL_PULSE_A = 5'h05;
  localparam logic [4:0] SEL_PULSE_B = 5'h06;
  localparam logic [4:0] SEL_PULSE_AB = 5'h07;
  localparam logic [4:0] SEL_DATA_A = 5'h0c;
  localparam logic [4:0] SEL_DATA_B = 5'h0d;
  localparam logic [4:0] SEL_DATA_AB = 5'h0e;
  localparam logic [4:0] SEL_TOGGLE = 5'h0f;
  localparam logic [4:0] SEL_LOW = 5'h10;
  localparam logic [4:0] SEL_HIGH = 5'h11;
  localparam logic [4:0] SEL_OSC = 5'h13;
endpackage

//--- pin_partner.sv
// partner model: system logic on the two general pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  // device side of the pins
  input wire logic pin0_out,
  input wire logic pin0_oe,
  input wire logic pin1_out,
  input wire logic pin1_oe,
  // levels the system puts on the pins while the device lets go
  input wire logic ext0,
  input wire logic ext1,
  // resolved pin levels fed back to the device
  output logic pin0_in,
  output logic pin1_in
);
  // device wins while it drives, so a driven pin reads back its own level
  assign pin0_in = pin0_oe ? pin0_out : ext0;
  assign pin1_in = pin1_oe ? pin1_out : ext1;
endmodule // pin_partner
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the general-pin function mux and unlock key
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk, rst, reg_wr, reg_rd, int_pol, int_drv, int_ena, sample_strobe, ext0, ext1, tog;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [6:0] src, target_addr, cur;
  logic pin0_in, pin0_out, pin0_oe, pin1_in, pin1_out, pin1_oe;
  logic [4:0] codes [12];
  logic [6:0] vecs [4];
  int errors, checks, cycles;

  pin_function_mux pin_function_mux_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_pol(int_pol), .int_drv(int_drv),
    .int_ena(int_ena), .irq(src[5]), .slot_window(src[0]), .pulse_a(src[1]), .pulse_b(src[2]),
    .data_cycle_a(src[3]), .data_cycle_b(src[4]), .sample_strobe(sample_strobe), .osc32k(src[6]),
    .pin0_in(pin0_in), .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin1_in(pin1_in), .pin1_out(pin1_out),
    .pin1_oe(pin1_oe), .target_addr(target_addr));
  pin_partner pin_partner_inst (.pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin1_out(pin1_out),
    .pin1_oe(pin1_oe), .ext0(ext0), .ext1(ext1), .pin0_in(pin0_in), .pin1_in(pin1_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is well under this; a hang lands here
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic try_addr(input logic [15:0] key, input logic e0, input logic e1, input logic [6:0] a,
    input logic ok);
    logic [15:0] v;
    wr(pin_mux_pkg::KEY_OFS, key);
    ext0 <= e0;
    ext1 <= e1;
    // pin levels pass a synchroniser before they gate the key
    repeat (6) @(posedge mclk);
    if (ok) cur = a;
    wr(pin_mux_pkg::ADDR_REG_OFS, {pin_mux_pkg::ADDR_WRITE_KEY, a, 1'b0});
    rd(pin_mux_pkg::KEY_OFS, v);
    cmp(v, key, "key readback");
    rd(pin_mux_pkg::ADDR_REG_OFS, v);
    cmp(v, {8'h00, cur, 1'b0}, "address read");
    cmp({9'h000, target_addr}, {9'h000, cur}, "target address");
  endtask

  // src bits: osc, irq, data b, data a, pulse b, pulse a, slot window
  function automatic logic fexp(input logic [4:0] c, input logic [6:0] v);
    case (c)
      5'h00, 5'h01: fexp = v[5];
      5'h02: fexp = v[0];
      5'h05: fexp = v[1];
      5'h06: fexp = v[2];
      5'h07: fexp = v[1] | v[2];
      5'h0c: fexp = v[3];
      5'h0d: fexp = v[4];
      5'h0e: fexp = v[3] | v[4];
      5'h10: fexp = 1'b0;
      5'h11: fexp = 1'b1;
      default: fexp = v[6];
    endcase
  endfunction

  initial begin
    {rst, reg_wr, reg_rd, int_pol, int_drv, int_ena, sample_strobe, ext0, ext1} = 9'h100;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    src = 7'h00;
    cur = 7'h32;
    codes = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h13};
    vecs = '{7'h00, 7'h55, 7'h2a, 7'h7f};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(pin_mux_pkg::ADDR_REG_OFS, d);
    cmp(d, 16'h0064, "address reset");
    rd(pin_mux_pkg::PIN_SEL_OFS, d);
    cmp(d, 16'h0000, "selector reset");
    rd(pin_mux_pkg::KEY_OFS, d);
    cmp(d, 16'h0000, "key reset");
    try_addr(16'h0000, 1'b1, 1'b1, 7'h11, 1'b0);
    try_addr(16'h04ad, 1'b0, 1'b0, 7'h28, 1'b1);
    try_addr(16'h44ad, 1'b0, 1'b1, 7'h12, 1'b0);
    try_addr(16'h44ad, 1'b1, 1'b0, 7'h13, 1'b1);
    try_addr(16'h84ad, 1'b1, 1'b0, 7'h14, 1'b0);
    try_addr(16'h84ad, 1'b0, 1'b1, 7'h15, 1'b1);
    try_addr(16'hc4ad, 1'b1, 1'b0, 7'h16, 1'b0);
    try_addr(16'hc4ad, 1'b1, 1'b1, 7'h17, 1'b1);
    @(posedge mclk);
    int_ena <= 1'b1;
    foreach (codes[i]) begin
      wr(pin_mux_pkg::PIN_SEL_OFS, {3'h0, codes[i], 3'h0, codes[i]});
      foreach (vecs[j]) begin
        @(posedge mclk);
        src <= vecs[j];
        // oscillator passes five flops, so allow it time to settle
        repeat (6) @(posedge mclk);
        #1;
        cmp({14'h0000, pin0_oe, pin0_out}, {14'h0001, fexp(codes[i], vecs[j])}, "pin0");
        cmp({14'h0000, pin1_oe, pin1_out}, (codes[i] == 5'h00) ? 16'h0000 : {14'h0001, fexp(codes[i], vecs[j])}, "pin1");
      end
    end
    // active-low open-drain interrupt: driven low only while asserted
    wr(pin_mux_pkg::PIN_SEL_OFS, 16'h0101);
    int_pol <= 1'b1;
    int_drv <= 1'b1;
    foreach (vecs[j]) begin
      @(posedge mclk);
      src <= vecs[j];
      repeat (3) @(posedge mclk);
      #1;
      cmp({14'h0000, pin0_oe, pin0_oe & pin0_out}, {14'h0000, vecs[j][5], 1'b0}, "open drain int");
    end
    // different constant levels on the two pins at once
    wr(pin_mux_pkg::PIN_SEL_OFS, 16'h1110);
    repeat (2) @(posedge mclk);
    #1;
    cmp({12'h000, pin0_oe, pin0_out, pin1_oe, pin1_out}, 16'h000b, "const levels");
    wr(pin_mux_pkg::PIN_SEL_OFS, 16'h0f0f);
    repeat (3) @(posedge mclk);
    #1;
    tog = pin0_out;
    repeat (3) begin
      @(posedge mclk);
      sample_strobe <= 1'b1;
      @(posedge mclk);
      sample_strobe <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      cmp({15'h0000, pin0_out}, {15'h0000, ~tog}, "toggle pin0");
      cmp({15'h0000, pin1_out}, {15'h0000, ~tog}, "toggle pin1");
      tog = pin0_out;
    end
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
